// >>> hw/icc_pkg.sv
package icc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ICC_ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ICC_ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ICC_ADDR_DATA = 8'h08;
  localparam logic [7:0] ICC_ADDR_EVENTS = 8'h0C;

  // ---------------------------------------------------------------
  // Control one fields
  // ---------------------------------------------------------------
  localparam int ICC_POS_IDLE_HALT = 13;
  localparam int ICC_POS_TSEL = 10;
  localparam int ICC_POS_CPI = 5;
  localparam int ICC_POS_OVF = 4;
  localparam int ICC_POS_BNE = 3;
  localparam int ICC_POS_MODE = 0;

  // ---------------------------------------------------------------
  // Control two fields
  // ---------------------------------------------------------------
  localparam int ICC_POS_CASCADE = 8;
  localparam int ICC_POS_TRIG = 7;
  localparam int ICC_POS_TSTAT = 6;
  localparam int ICC_POS_SRC = 0;
  localparam logic [15:0] ICC_RESET_CTRL_ONE = 16'h0000;
  localparam logic [4:0] ICC_RESET_SRC = 5'h0D;

  // ---------------------------------------------------------------
  // Timebase codes
  // ---------------------------------------------------------------
  localparam logic [2:0] ICC_TB_T3 = 3'h0;
  localparam logic [2:0] ICC_TB_T2 = 3'h1;
  localparam logic [2:0] ICC_TB_T4 = 3'h2;
  localparam logic [2:0] ICC_TB_T5 = 3'h3;
  localparam logic [2:0] ICC_TB_T1 = 3'h4;
  localparam logic [2:0] ICC_TB_PCLK = 3'h7;

  // ---------------------------------------------------------------
  // Capture modes
  // ---------------------------------------------------------------
  localparam logic [2:0] ICC_MODE_OFF = 3'h0;
  localparam logic [2:0] ICC_MODE_EDGE = 3'h1;
  localparam logic [2:0] ICC_MODE_FALL = 3'h2;
  localparam logic [2:0] ICC_MODE_RISE = 3'h3;
  localparam logic [2:0] ICC_MODE_RISE4 = 3'h4;
  localparam logic [2:0] ICC_MODE_RISE16 = 3'h5;
  localparam logic [2:0] ICC_MODE_UNUSED = 3'h6;
  localparam logic [2:0] ICC_MODE_WAKE = 3'h7;

  localparam int ICC_FIFO_DEPTH = 4;
  localparam int ICC_CNT_WIDTH = 16;
  localparam int ICC_SRC_COUNT = 32;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    logic t4;
    logic t5;
  } icc_tick_type;

  typedef struct packed {
    logic [3:0] capture;
    logic [3:0] compare;
    logic [4:0] timer;
    logic [2:0] comparator;
    logic converter;
    logic charge_time;
    logic generator;
  } icc_src_type;

endpackage

// >>> hw/icc_channel.sv
`timescale 1ns/100ps
// Function
// - Timebase select picks capture clock source
// - Code 100 uses timer one synchronous clock
// - Interrupt every one to four captures
// - Interrupt count ignored in modes 001/111
// - Overflow flag set on full-buffer capture
// - Not-empty flag while unread values remain
// - Mode 111 is rising-edge wake interrupt only
// - Mode 100 captures every fourth rising edge
// - Modes 000 and 110 disable channel
// - Cascade needs both pair bits set
// - Trigger status set by source, software writable
// - Source codes 11111/00000 select nothing
// - Codes 01111..01011 select timers five..one
// - Codes select capture and compare channels
// - Codes select charge unit, converter, comparators
// - Code 01010 selects trigger generator output
// - Four-entry FIFO holds captured values
// - Own 16-bit counter on selected clock
module icc_channel
  import icc_pkg::*;
#(
  parameter int CNT_WIDTH = ICC_CNT_WIDTH,
  parameter int DEPTH = ICC_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic capture_pin,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire icc_tick_type timer_tick,
  input wire icc_src_type sync_sources,
  input wire logic partner_cascade,
  output logic cascade_active,
  output logic capture_event,
  output logic capture_irq
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic idle_halt;
  logic [2:0] timebase_select;
  logic [1:0] captures_per_irq;
  logic buffer_overflow_flag;
  logic [2:0] capture_mode_sel;
  logic cascade_enable;
  logic trigger_not_sync;
  logic trigger_running_status;
  logic [4:0] source_select;
  logic [CNT_WIDTH-1:0] capture_counter;
  logic [CNT_WIDTH-1:0] fifo_mem [DEPTH];
  logic [1:0] rd_ptr;
  logic [1:0] wr_ptr;
  logic [2:0] fill;
  logic [1:0] irq_count;
  logic [3:0] pre_count;
  logic pin_prev;

  // ---------------------------------------------------------------
  // Bus address phase
  // ---------------------------------------------------------------
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  wire bus_take = hsel && hready && htrans[1];
  wire wr_one = ph_valid && ph_write && ph_addr == ICC_ADDR_CTRL_ONE;
  wire wr_two = ph_valid && ph_write && ph_addr == ICC_ADDR_CTRL_TWO;
  wire rd_data = ph_valid && !ph_write && ph_addr == ICC_ADDR_DATA;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_valid <= bus_take;
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  // Idle halt also clears the counter to zero and blocks captures
  wire halted = idle_halt && cpu_idle;
  wire mode_off = capture_mode_sel == ICC_MODE_OFF
    || capture_mode_sel == ICC_MODE_UNUSED;
  wire mode_wake = capture_mode_sel == ICC_MODE_WAKE;
  wire active = !mode_off && !mode_wake && !halted;
  assign cascade_active = cascade_enable && partner_cascade;

  // Timebase tick selection
  wire tb_tick = (timebase_select == ICC_TB_PCLK) ? 1'b1 :
    (timebase_select == ICC_TB_T3) ? timer_tick.t3 :
    (timebase_select == ICC_TB_T2) ? timer_tick.t2 :
    (timebase_select == ICC_TB_T4) ? timer_tick.t4 :
    (timebase_select == ICC_TB_T5) ? timer_tick.t5 :
    (timebase_select == ICC_TB_T1) ? timer_tick.t1 :
    1'b0;

  // ---------------------------------------------------------------
  // Source selection, one vector indexed by code
  // ---------------------------------------------------------------
  // Reserved and none codes stay zero
  wire [ICC_SRC_COUNT-1:0] src_vec = {
    1'b0, 1'b0, 1'b0,
    sync_sources.charge_time,
    sync_sources.converter,
    sync_sources.comparator,
    4'h0,
    sync_sources.capture,
    sync_sources.timer,
    sync_sources.generator,
    5'h00,
    sync_sources.compare,
    1'b0
  };
  wire src_pulse = src_vec[source_select];

  // ---------------------------------------------------------------
  // Edge detection and prescale
  // ---------------------------------------------------------------
  wire rise = capture_pin && !pin_prev;
  wire fall = !capture_pin && pin_prev;
  logic edge_hit;
  always_comb begin
    edge_hit = 1'b0;
    case (capture_mode_sel)
      ICC_MODE_EDGE: edge_hit = rise || fall;
      ICC_MODE_FALL: edge_hit = fall;
      ICC_MODE_RISE: edge_hit = rise;
      ICC_MODE_RISE4: edge_hit = rise && pre_count[1:0] == 2'h3;
      ICC_MODE_RISE16: edge_hit = rise && pre_count == 4'hF;
      default: edge_hit = 1'b0;
    endcase
  end
  // Trigger mode only captures while the running status is set, by the source or by software
  wire run_ok = !trigger_not_sync || trigger_running_status;
  wire cap = active && edge_hit && run_ok;
  wire full = fill == 3'(DEPTH);
  wire push = cap && !full;
  wire pop = rd_data && fill != 3'h0;
  assign capture_event = cap;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev <= 1'b0;
      pre_count <= 4'h0;
    end else begin
      pin_prev <= capture_pin;
      if (!active) begin
        pre_count <= 4'h0;
      end else if (rise) begin
        pre_count <= pre_count + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      capture_counter <= '0;
    end else if (!active || !run_ok) begin
      capture_counter <= '0;
    end else if (!trigger_not_sync && src_pulse) begin
      capture_counter <= '0;
    end else if (tb_tick) begin
      capture_counter <= capture_counter + CNT_WIDTH'(1);
    end
  end

  // ---------------------------------------------------------------
  // FIFO
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifo_mem[wr_ptr] <= capture_counter;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      fill <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      fill <= fill + 3'(push) - 3'(pop);
    end
  end

  // Overflow clears once the buffer drains to empty or the mode is off
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      buffer_overflow_flag <= 1'b0;
    end else if (cap && full) begin
      buffer_overflow_flag <= 1'b1;
    end else if (fill == 3'h0 || mode_off) begin
      buffer_overflow_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt counting
  // ---------------------------------------------------------------
  wire cpi_bypass = capture_mode_sel == ICC_MODE_EDGE;
  wire wake_irq = mode_wake && rise && (cpu_sleep || cpu_idle);
  wire next_irq = wake_irq
    || (cap && (cpi_bypass || irq_count == captures_per_irq));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_count <= 2'h0;
      capture_irq <= 1'b0;
    end else begin
      capture_irq <= next_irq;
      if (!active || wr_one) begin
        irq_count <= 2'h0;
      end else if (cap) begin
        irq_count <= (irq_count == captures_per_irq) ? 2'h0
          : irq_count + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idle_halt <= ICC_RESET_CTRL_ONE[ICC_POS_IDLE_HALT];
      timebase_select <= ICC_TB_T3;
      captures_per_irq <= 2'h0;
      capture_mode_sel <= ICC_MODE_OFF;
      cascade_enable <= 1'b0;
      trigger_not_sync <= 1'b0;
      source_select <= ICC_RESET_SRC;
    end else begin
      if (wr_one) begin
        idle_halt <= hwdata[ICC_POS_IDLE_HALT];
        timebase_select <= hwdata[ICC_POS_TSEL +: 3];
        captures_per_irq <= hwdata[ICC_POS_CPI +: 2];
        capture_mode_sel <= hwdata[ICC_POS_MODE +: 3];
      end
      if (wr_two) begin
        cascade_enable <= hwdata[ICC_POS_CASCADE];
        trigger_not_sync <= hwdata[ICC_POS_TRIG];
        source_select <= hwdata[ICC_POS_SRC +: 5];
      end
    end
  end

  // Source set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trigger_running_status <= 1'b0;
    end else if (trigger_not_sync && src_pulse) begin
      trigger_running_status <= 1'b1;
    end else if (wr_two) begin
      trigger_running_status <= hwdata[ICC_POS_TSTAT];
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire [15:0] ctrl_one = {2'h0, idle_halt, timebase_select, 3'h0,
    captures_per_irq, buffer_overflow_flag, fill != 3'h0,
    capture_mode_sel};
  wire [15:0] ctrl_two = {7'h00, cascade_enable, trigger_not_sync,
    trigger_running_status, 1'b0, source_select};
  // Read data follows the data phase so a pop returns what it removes
  always_comb begin
    hrdata = 32'h0000_0000;
    if (ph_valid && !ph_write) begin
      case (ph_addr)
        ICC_ADDR_CTRL_ONE: hrdata = {16'h0000, ctrl_one};
        ICC_ADDR_CTRL_TWO: hrdata = {16'h0000, ctrl_two};
        ICC_ADDR_DATA: hrdata = {16'h0000, fifo_mem[rd_ptr]};
        ICC_ADDR_EVENTS: hrdata = {29'h0, fill};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_off_no_cap;
    @(posedge clk_sys) disable iff (!reset_n)
    mode_off |-> !capture_event;
  endproperty
  a_off_no_cap: assert property (p_off_no_cap)
    else $error("capture while disabled");
  property p_full_ovf;
    @(posedge clk_sys) disable iff (!reset_n)
    (cap && full) |=> buffer_overflow_flag;
  endproperty
  a_full_ovf: assert property (p_full_ovf)
    else $error("overflow flag not set");
  property p_fill_push;
    @(posedge clk_sys) disable iff (!reset_n)
    (push && !pop) |=> fill == $past(fill) + 3'h1;
  endproperty
  a_fill_push: assert property (p_fill_push)
    else $error("push did not grow fill");
  property p_depth;
    @(posedge clk_sys) disable iff (!reset_n)
    fill <= 3'(DEPTH);
  endproperty
  a_depth: assert property (p_depth)
    else $error("fifo overfilled");
  property p_pop;
    @(posedge clk_sys) disable iff (!reset_n)
    (pop && !push && fill == 3'h1) |=> ctrl_one[ICC_POS_BNE] == 1'b0;
  endproperty
  a_pop: assert property (p_pop)
    else $error("not-empty stuck after last pop");
  property p_halt;
    @(posedge clk_sys) disable iff (!reset_n)
    halted |=> capture_counter == '0;
  endproperty
  a_halt: assert property (p_halt)
    else $error("counter ran in idle halt");
  property p_irq4;
    @(posedge clk_sys) disable iff (!reset_n)
    (capture_mode_sel == ICC_MODE_RISE && captures_per_irq == 2'h3
      && cap && irq_count == 2'h0) |=> !capture_irq;
  endproperty
  a_irq4: assert property (p_irq4)
    else $error("irq too early");
  property p_tstat;
    @(posedge clk_sys) disable iff (!reset_n)
    (trigger_not_sync && src_pulse) |=> trigger_running_status;
  endproperty
  a_tstat: assert property (p_tstat)
    else $error("trigger status not set");

endmodule

// >>> bench/icc_partner.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far side: capture pin, timer ticks, sources
// ----------------------------------------
module icc_partner
  import icc_pkg::*;
(
  input wire logic clk_sys,
  output logic capture_pin,
  output icc_tick_type timer_tick,
  output icc_src_type sync_sources
);
  logic [4:0] cyc = 5'h00;
  initial begin
    capture_pin = 1'b0;
    sync_sources = '0;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 5'h01;
  end
  // Timers one to five tick every 2, 4, 8, 16, 32 cycles
  assign timer_tick = {cyc[0], &cyc[1:0], &cyc[2:0], &cyc[3:0], &cyc};
  // One rising and one falling edge, one cycle apart
  task pulse_pin();
    @(posedge clk_sys);
    capture_pin <= 1'b1;
    @(posedge clk_sys);
    capture_pin <= 1'b0;
  endtask
  task pulse_src(input logic [$bits(icc_src_type)-1:0] mask);
    @(posedge clk_sys);
    sync_sources <= icc_src_type'(mask);
    @(posedge clk_sys);
    sync_sources <= '0;
  endtask
endmodule

// >>> bench/icc_channel_bench.sv
`timescale 1ns/100ps
module icc_channel_bench
  import icc_pkg::*;
  ;
  logic clk_sys, reset_n, hwrite, hsel, cpu_idle, cpu_sleep;
  logic partner_cascade, hreadyout, hresp, cascade_active;
  logic capture_event, capture_irq, capture_pin;
  logic [31:0] haddr, hwdata, hrdata, rd, v0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  icc_tick_type timer_tick;
  icc_src_type sync_sources;
  int failures = 0;
  int checked = 0;
  int irqs = 0;
  int caps = 0;
  int base = 0;

  icc_channel dut_u (.clk_sys, .reset_n, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hsel, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .capture_pin, .cpu_idle, .cpu_sleep, .timer_tick,
    .sync_sources, .partner_cascade, .cascade_active, .capture_event,
    .capture_irq);
  icc_partner ptn_u (.clk_sys, .capture_pin, .timer_tick,
    .sync_sources);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (capture_irq === 1'b1) irqs <= irqs + 1;
    if (capture_event === 1'b1) caps <= caps + 1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task tally_and_finish();
    $display("Checks %0d, errors %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Address phase held until hready, then data phase until hready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task pulses(input int n, input int gap);
    repeat (n) begin
      ptn_u.pulse_pin();
      repeat (gap) @(posedge clk_sys);
    end
  endtask
  task drain();
    repeat (4) bus(1'b0, ICC_ADDR_DATA, 32'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset();
    rdc(ICC_ADDR_CTRL_ONE, 32'h0);
    rdc(ICC_ADDR_CTRL_TWO, 32'h0000000D);
    rdc(8'h10, 32'h0);
    wr(ICC_ADDR_CTRL_ONE, 32'h18);
    rdc(ICC_ADDR_CTRL_ONE, 32'h0);
  endtask
  task t_timebase();
    logic [31:0] ex [8];
    ex = '{32'h04, 32'h08, 32'h02, 32'h01, 32'h10, 32'h0, 32'h0, 32'h20};
    for (int c = 0; c < 8; c++) begin
      wr(ICC_ADDR_CTRL_ONE, 32'(c << 10) | 32'h3);
      pulses(1, 30);
      ptn_u.pulse_pin();
      bus(1'b0, ICC_ADDR_DATA, 32'h0);
      v0 = rd;
      bus(1'b0, ICC_ADDR_DATA, 32'h0);
      check((rd - v0) & 32'hFFFF, ex[c]);
    end
  endtask
  task t_fifo();
    wr(ICC_ADDR_CTRL_ONE, 32'h1C03);
    base = caps;
    pulses(5, 2);
    check(32'(caps - base), 32'h5);
    rdc(ICC_ADDR_EVENTS, 32'h4);
    rdc(ICC_ADDR_CTRL_ONE, 32'h1C1B);
    bus(1'b0, ICC_ADDR_DATA, 32'h0);
    v0 = rd;
    for (int i = 1; i < 4; i++) begin
      bus(1'b0, ICC_ADDR_DATA, 32'h0);
      check((rd - v0) & 32'hFFFF, 32'(4 * i));
    end
    rdc(ICC_ADDR_CTRL_ONE, 32'h1C03);
    check({31'h0, hresp}, 32'h0);
  endtask
  task t_irq();
    logic [31:0] ex [4];
    ex = '{32'h8, 32'h4, 32'h2, 32'h2};
    for (int c = 0; c < 4; c++) begin
      wr(ICC_ADDR_CTRL_ONE, 32'h1C03 | 32'(c << 5));
      base = irqs;
      pulses(4, 1);
      drain();
      pulses(4, 1);
      drain();
      check(32'(irqs - base), ex[c]);
    end
    wr(ICC_ADDR_CTRL_ONE, 32'h1C61);
    base = irqs;
    pulses(2, 1);
    drain();
    check(32'(irqs - base), 32'h4);
  endtask
  task t_modes();
    logic [31:0] m [5];
    int n [5];
    logic [31:0] ex [5];
    m = '{32'h0, 32'h6, 32'h4, 32'h2, 32'h5};
    n = '{4, 4, 8, 3, 16};
    ex = '{32'h0, 32'h0, 32'h2, 32'h3, 32'h1};
    for (int i = 0; i < 5; i++) begin
      wr(ICC_ADDR_CTRL_ONE, 32'h1C00 | m[i]);
      pulses(n[i], 1);
      rdc(ICC_ADDR_EVENTS, ex[i]);
      drain();
    end
    wr(ICC_ADDR_CTRL_ONE, 32'h1C07);
    base = irqs;
    @(posedge clk_sys);
    cpu_sleep <= 1'b1;
    pulses(1, 2);
    cpu_sleep <= 1'b0;
    pulses(1, 2);
    cpu_idle <= 1'b1;
    pulses(1, 2);
    check(32'(irqs - base), 32'h2);
    wr(ICC_ADDR_CTRL_ONE, 32'h3C03);
    pulses(1, 2);
    rdc(ICC_ADDR_EVENTS, 32'h0);
    wr(ICC_ADDR_CTRL_ONE, 32'h1C03);
    pulses(1, 2);
    rdc(ICC_ADDR_EVENTS, 32'h1);
    cpu_idle <= 1'b0;
    drain();
  endtask
  task t_cascade();
    for (int i = 0; i < 4; i++) begin
      partner_cascade <= i[0];
      wr(ICC_ADDR_CTRL_TWO, {23'h000000, i[1], 8'h0D});
      @(posedge clk_sys);
      check({31'h0, cascade_active}, 32'(i == 3));
    end
  endtask
  task t_sync();
    wr(ICC_ADDR_CTRL_ONE, 32'h1C03);
    repeat (40) @(posedge clk_sys);
    ptn_u.pulse_src(19'h00100);
    ptn_u.pulse_pin();
    bus(1'b0, ICC_ADDR_DATA, 32'h0);
    check({31'h0, rd[15:0] < 16'h0008}, 32'h1);
  endtask
  task t_src();
    logic [31:0] cd [13];
    int ix [13];
    logic [18:0] mk;
    // Analog sources used only as triggers, capture codes are neighbours
    cd = '{32'h1F, 32'h00, 32'h0F, 32'h0B, 32'h13, 32'h10, 32'h04,
      32'h01, 32'h1C, 32'h1B, 32'h18, 32'h1A, 32'h0A};
    ix = '{-1, -1, 10, 6, 18, 15, 14, 11, 1, 2, 3, 5, 0};
    for (int i = 0; i < 13; i++) begin
      mk = (ix[i] < 0) ? 19'h0 : 19'h1 << ix[i];
      wr(ICC_ADDR_CTRL_TWO, 32'h80 | cd[i]);
      ptn_u.pulse_src(~mk);
      rdc(ICC_ADDR_CTRL_TWO, 32'h80 | cd[i]);
      if (ix[i] >= 0) begin
        pulses(1, 1);
        rdc(ICC_ADDR_EVENTS, 32'h0);
        ptn_u.pulse_src(mk);
        rdc(ICC_ADDR_CTRL_TWO, 32'hC0 | cd[i]);
        pulses(1, 1);
        rdc(ICC_ADDR_EVENTS, 32'h1);
        drain();
      end
    end
    wr(ICC_ADDR_CTRL_TWO, 32'hDF);
    rdc(ICC_ADDR_CTRL_TWO, 32'hDF);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hsel = 1'b0;
    cpu_idle = 1'b0;
    cpu_sleep = 1'b0;
    partner_cascade = 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_timebase();
    t_fifo();
    t_irq();
    t_modes();
    t_cascade();
    t_sync();
    t_src();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end
endmodule
